// ==== cbj_top.sv ====
/*
  capture-effect backoff selection, jabber and receive watchdog
  supervision, with an axi4-lite register slave.
  assumes the mac pulses coll_pulse with its attempt count, pulses
  tx_ok after a good frame and rx_frame_seen on any sensed frame.
*/
`timescale 1ns/10ps
`include "cbj_defines.svh"

module cbj_top #(
  parameter int unsigned SLOT_CYCLES = `CBJ_SLOT_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // mac side
  input wire logic tx_active,
  input wire logic rx_active,
  input wire logic carrier_busy,
  input wire logic tx_ok,
  input wire logic rx_frame_seen,
  input wire logic coll_pulse,
  input wire logic [3:0] coll_attempt,
  // backoff result
  output logic backoff_busy,
  output logic backoff_done,
  // supervision
  output logic tx_cutoff,
  output logic rx_cutoff,
  output logic col_to_mac,
  output logic tx_desc_close,
  output logic tx_jabber_timeout_flag,
  output logic tx_late_collision_flag,
  output logic rx_desc_close,
  output logic rx_watchdog_expired_flag,
  // interrupt
  output logic irq
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [9:0] bo_mask(input logic [3:0] n);
    logic [3:0] k;
    k = (n > `CBJ_K_MAX) ? `CBJ_K_MAX : n;
    bo_mask = 10'((11'h001 << k) - 11'h001);
  endfunction

  localparam logic [13:0] SLOT_LAST = 14'(SLOT_CYCLES - 1);

  logic [15:0] rnd;
  cbj_lfsr u_lfsr (
    .clk (clk),
    .rst (rst),
    .rnd (rnd)
  );

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  logic aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
  logic [7:0] awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [1:0] br_q, br_d, rr_q, rr_d;
  logic wr_fire;
  logic [1:0] ctrl_q;
  logic [`CBJ_LIM_W-1:0] jlim_q, wlim_q;
  logic [`CBJ_EV_W-1:0] ist_q, ien_q, iclr;
  logic mode20_q, tx_dis_q, rx_dis_q;

  assign wr_fire = aw_q & w_q & ~b_q;

  always_comb begin
    aw_d = aw_q;
    w_d = w_q;
    awa_d = awa_q;
    wd_d = wd_q;
    b_d = b_q;
    br_d = br_q;
    r_d = r_q;
    rd_d = rd_q;
    rr_d = rr_q;
    if (s_axi_awvalid & ~aw_q) begin
      aw_d = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid & ~w_q) begin
      w_d = 1'b1;
      wd_d = s_axi_wdata;
    end
    if (wr_fire) begin
      aw_d = 1'b0;
      w_d = 1'b0;
      b_d = 1'b1;
      unique case (awa_q)
        `CBJ_ADDR_CTRL, `CBJ_ADDR_JAB_LIM, `CBJ_ADDR_WDG_LIM,
        `CBJ_ADDR_INT_CLR, `CBJ_ADDR_INT_EN: br_d = `CBJ_RESP_OK;
        default: br_d = `CBJ_RESP_ERR;
      endcase
    end
    if (b_q & s_axi_bready) begin
      b_d = 1'b0;
    end
    if (s_axi_arvalid & ~r_q) begin
      r_d = 1'b1;
      rr_d = `CBJ_RESP_OK;
      unique case (s_axi_araddr)
        `CBJ_ADDR_CTRL: rd_d = {30'h0, ctrl_q};
        `CBJ_ADDR_JAB_LIM: rd_d = {8'h0, jlim_q};
        `CBJ_ADDR_WDG_LIM: rd_d = {8'h0, wlim_q};
        `CBJ_ADDR_STATUS:
          rd_d = {28'h0, rx_dis_q, tx_dis_q, backoff_busy, mode20_q};
        `CBJ_ADDR_INT_STAT: rd_d = {29'h0, ist_q};
        `CBJ_ADDR_INT_CLR: rd_d = 32'h0;
        `CBJ_ADDR_INT_EN: rd_d = {29'h0, ien_q};
        default: begin
          rd_d = 32'h0;
          rr_d = `CBJ_RESP_ERR;
        end
      endcase
    end else if (r_q & s_axi_rready) begin
      r_d = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 8'h00;
      wd_q <= 32'h0;
      b_q <= 1'b0;
      br_q <= 2'h0;
      r_q <= 1'b0;
      rd_q <= 32'h0;
      rr_q <= 2'h0;
    end else begin
      aw_q <= aw_d;
      w_q <= w_d;
      awa_q <= awa_d;
      wd_q <= wd_d;
      b_q <= b_d;
      br_q <= br_d;
      r_q <= r_d;
      rd_q <= rd_d;
      rr_q <= rr_d;
    end
  end

  assign s_axi_awready = ~aw_q;
  assign s_axi_wready = ~w_q;
  assign s_axi_bvalid = b_q;
  assign s_axi_bresp = br_q;
  assign s_axi_arready = ~r_q;
  assign s_axi_rvalid = r_q;
  assign s_axi_rdata = rd_q;
  assign s_axi_rresp = rr_q;

  // ----------------------------------------------------------------
  // control registers and interrupt
  // ----------------------------------------------------------------
  logic [1:0] ctrl_d;
  logic [`CBJ_LIM_W-1:0] jlim_d, wlim_d;
  logic [`CBJ_EV_W-1:0] ist_d, ien_d, ev;

  assign iclr = (wr_fire && awa_q == `CBJ_ADDR_INT_CLR && s_axi_wstrb[0])
              ? wd_q[`CBJ_EV_W-1:0] : '0;

  always_comb begin
    ctrl_d = ctrl_q;
    jlim_d = jlim_q;
    wlim_d = wlim_q;
    ien_d = ien_q;
    if (wr_fire && s_axi_wstrb[0]) begin
      unique case (awa_q)
        `CBJ_ADDR_CTRL: ctrl_d = wd_q[1:0];
        `CBJ_ADDR_JAB_LIM: jlim_d = wd_q[`CBJ_LIM_W-1:0];
        `CBJ_ADDR_WDG_LIM: wlim_d = wd_q[`CBJ_LIM_W-1:0];
        `CBJ_ADDR_INT_EN: ien_d = wd_q[`CBJ_EV_W-1:0];
        default: ;
      endcase
    end
    // set wins over clear
    ist_d = (ist_q & ~iclr) | ev;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_q <= `CBJ_CTRL_RST;
      jlim_q <= `CBJ_JAB_LIM_RST;
      wlim_q <= `CBJ_WDG_LIM_RST;
      ien_q <= '0;
      ist_q <= '0;
    end else begin
      ctrl_q <= ctrl_d;
      jlim_q <= jlim_d;
      wlim_q <= wlim_d;
      ien_q <= ien_d;
      ist_q <= ist_d;
    end
  end

  assign irq = |(ist_q & ien_q);

  // ----------------------------------------------------------------
  // backoff selection and slot timer
  // ----------------------------------------------------------------
  cbj_pkg::cbj_bo_state_t st_q, st_d;
  logic mode20_d, freeze;
  logic [3:0] n_q, n_d;
  cbj_pkg::cbj_slots_t left_q, left_d;
  logic [13:0] sc_q, sc_d;
  logic done_d, done_q;

  // stall only on the first collision of a 2-0 frame
  assign freeze = ctrl_q[`CBJ_CTRL_ECR] & mode20_q & (n_q == 4'h1)
                & carrier_busy;

  always_comb begin
    mode20_d = mode20_q;
    if (rx_frame_seen) begin
      mode20_d = 1'b0;
    end
    if (tx_ok) begin
      mode20_d = 1'b1;
    end
    if (~ctrl_q[`CBJ_CTRL_CME]) begin
      mode20_d = 1'b0;
    end
    st_d = st_q;
    n_d = n_q;
    left_d = left_q;
    sc_d = sc_q;
    done_d = 1'b0;
    unique case (st_q)
      cbj_pkg::CBJ_BO_IDLE: begin
        if (coll_pulse) begin
          n_d = coll_attempt;
          st_d = cbj_pkg::CBJ_BO_LOAD;
        end
      end
      cbj_pkg::CBJ_BO_LOAD: begin
        sc_d = 14'h0;
        st_d = cbj_pkg::CBJ_BO_RUN;
        if (mode20_q && n_q == 4'h1) begin
          left_d = `CBJ_TWO_SLOTS;
        end else if (mode20_q && n_q == 4'h2) begin
          left_d = `CBJ_ZERO_SLOTS;
        end else begin
          left_d = rnd[9:0] & bo_mask(n_q);
        end
      end
      cbj_pkg::CBJ_BO_RUN: begin
        if (left_q == 10'h0) begin
          done_d = 1'b1;
          st_d = cbj_pkg::CBJ_BO_IDLE;
        end else if (~freeze) begin
          if (sc_q == SLOT_LAST) begin
            sc_d = 14'h0;
            left_d = left_q - 10'h001;
          end else begin
            sc_d = sc_q + 14'h0001;
          end
        end
      end
      default: st_d = cbj_pkg::CBJ_BO_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode20_q <= 1'b0;
      st_q <= cbj_pkg::CBJ_BO_IDLE;
      n_q <= 4'h0;
      left_q <= 10'h0;
      sc_q <= 14'h0;
      done_q <= 1'b0;
    end else begin
      mode20_q <= mode20_d;
      st_q <= st_d;
      n_q <= n_d;
      left_q <= left_d;
      sc_q <= sc_d;
      done_q <= done_d;
    end
  end

  assign backoff_busy = (st_q != cbj_pkg::CBJ_BO_IDLE);
  assign backoff_done = done_q;

  // ----------------------------------------------------------------
  // jabber and watchdog timers
  // ----------------------------------------------------------------
  logic [`CBJ_LIM_W-1:0] jc_q, jc_d, wc_q, wc_d;
  logic jab_exp, wdg_exp, tx_dis_d, rx_dis_d;
  logic txc_d, txc_q, rxc_d, rxc_q, col_d, col_q;

  assign jab_exp = tx_active & ~tx_dis_q & (jc_q >= jlim_q);
  assign wdg_exp = rx_active & ~rx_dis_q & (wc_q >= wlim_q);
  assign ev = {done_q, wdg_exp, jab_exp};

  always_comb begin
    jc_d = tx_active ? jc_q + `CBJ_LIM_W'(1) : '0;
    wc_d = rx_active ? wc_q + `CBJ_LIM_W'(1) : '0;
    if (jc_q == '1) jc_d = jc_q;
    if (wc_q == '1) wc_d = wc_q;
    // paths stay off until software clears the event
    tx_dis_d = tx_dis_q;
    rx_dis_d = rx_dis_q;
    if (iclr[`CBJ_EV_JAB] | iclr[`CBJ_EV_WDG]) begin
      tx_dis_d = 1'b0;
      rx_dis_d = 1'b0;
    end
    if (jab_exp | wdg_exp) begin
      tx_dis_d = 1'b1;
      rx_dis_d = 1'b1;
    end
    txc_d = jab_exp;
    rxc_d = wdg_exp;
    col_d = tx_dis_d & tx_active & (jab_exp | col_q);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      jc_q <= '0;
      wc_q <= '0;
      tx_dis_q <= 1'b0;
      rx_dis_q <= 1'b0;
      txc_q <= 1'b0;
      rxc_q <= 1'b0;
      col_q <= 1'b0;
    end else begin
      jc_q <= jc_d;
      wc_q <= wc_d;
      tx_dis_q <= tx_dis_d;
      rx_dis_q <= rx_dis_d;
      txc_q <= txc_d;
      rxc_q <= rxc_d;
      col_q <= col_d;
    end
  end

  assign tx_cutoff = tx_dis_q;
  assign rx_cutoff = rx_dis_q;
  assign col_to_mac = col_q;
  assign tx_desc_close = txc_q;
  assign tx_jabber_timeout_flag = txc_q;
  assign tx_late_collision_flag = txc_q;
  assign rx_desc_close = rxc_q;
  assign rx_watchdog_expired_flag = rxc_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_two_slots: assert property (@(posedge clk) disable iff (rst)
    st_q == cbj_pkg::CBJ_BO_LOAD && mode20_q && n_q == 4'h1
    |=> left_q == 10'h002) else $error("2-0 first backoff not 2 slots");
  a_zero_slots: assert property (@(posedge clk) disable iff (rst)
    st_q == cbj_pkg::CBJ_BO_LOAD && mode20_q && n_q == 4'h2
    |=> ##1 done_q) else $error("2-0 second backoff not zero");
  a_rand_bound: assert property (@(posedge clk) disable iff (rst)
    st_q == cbj_pkg::CBJ_BO_LOAD && !mode20_q
    |=> (left_q & ~bo_mask(n_q)) == 10'h0) else $error("random over 2^k");
  a_mode_off: assert property (@(posedge clk) disable iff (rst)
    !ctrl_q[`CBJ_CTRL_CME] |=> !mode20_q) else $error("2-0 while disabled");
  a_seen_clear: assert property (@(posedge clk) disable iff (rst)
    rx_frame_seen && !tx_ok |=> !mode20_q) else $error("2-0 kept after frame");
  a_freeze_hold: assert property (@(posedge clk) disable iff (rst)
    st_q == cbj_pkg::CBJ_BO_RUN && freeze && left_q != 10'h0
    |=> $stable(sc_q) && $stable(left_q)) else $error("timer ran when frozen");
  a_run_free: assert property (@(posedge clk) disable iff (rst)
    st_q == cbj_pkg::CBJ_BO_RUN && n_q != 4'h1 && left_q != 10'h0
    |=> sc_q != $past(sc_q)) else $error("timer paused");
  a_jab_paths: assert property (@(posedge clk) disable iff (rst)
    jab_exp || wdg_exp |=> tx_cutoff && rx_cutoff) else $error("paths on");
  a_jab_desc: assert property (@(posedge clk) disable iff (rst)
    jab_exp |=> tx_desc_close && tx_jabber_timeout_flag
    && tx_late_collision_flag ##1 !tx_desc_close) else $error("tx close");
  a_jab_col: assert property (@(posedge clk) disable iff (rst)
    jab_exp ##1 tx_active |-> col_to_mac) else $error("no collision");
  a_wdg_desc: assert property (@(posedge clk) disable iff (rst)
    wdg_exp |=> rx_desc_close && rx_watchdog_expired_flag && rx_cutoff)
    else $error("rx close missing");

endmodule

// ==== cbj_defines.svh ====
/*
  register offsets, field positions, reset values and timing counts
  for the capture backoff / jabber supervision block.
  assumes inclusion by bare name; holds definitions only.
*/
`ifndef CBJ_DEFINES_SVH
`define CBJ_DEFINES_SVH

// ----------------------------------------------------------------
// register map (byte addresses)
// ----------------------------------------------------------------
`define CBJ_ADDR_CTRL     8'h00
`define CBJ_ADDR_JAB_LIM  8'h04
`define CBJ_ADDR_WDG_LIM  8'h08
`define CBJ_ADDR_STATUS   8'h0c
`define CBJ_ADDR_INT_STAT 8'h10
`define CBJ_ADDR_INT_CLR  8'h14
`define CBJ_ADDR_INT_EN   8'h18

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define CBJ_CTRL_CME      0
`define CBJ_CTRL_ECR      1
`define CBJ_EV_JAB        0
`define CBJ_EV_WDG        1
`define CBJ_EV_BO_DONE    2
`define CBJ_EV_W          3
`define CBJ_LIM_W         24

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CBJ_CTRL_RST      2'h0
`define CBJ_JAB_LIM_RST   24'h07a120
`define CBJ_WDG_LIM_RST   24'h07a120

// ----------------------------------------------------------------
// timing, backoff limit and response codes
// ----------------------------------------------------------------
`define CBJ_CLK_PS        4000
`define CBJ_SLOT_NS       51200
`define CBJ_SLOT_CYC      ((`CBJ_SLOT_NS * 1000) / `CBJ_CLK_PS)
`define CBJ_TWO_SLOTS     10'h002
`define CBJ_ZERO_SLOTS    10'h000
`define CBJ_K_MAX         4'ha
`define CBJ_RESP_OK       2'h0
`define CBJ_RESP_ERR      2'h2

`endif

// ==== cbj_pkg.sv ====
/*
  types shared by the capture backoff / jabber supervision block.
  assumes nothing of its surroundings.
*/
package cbj_pkg;

  typedef enum logic [1:0] {
    CBJ_BO_IDLE,
    CBJ_BO_LOAD,
    CBJ_BO_RUN
  } cbj_bo_state_t;

  typedef logic [9:0] cbj_slots_t;

endpackage

// ==== cbj_lfsr.sv ====
/*
  free-running 16-bit maximal-length lfsr used as the random source
  for backoff draws. assumes a single clock and async high reset.
*/
`timescale 1ns/10ps
module cbj_lfsr (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // random word
  output logic [15:0] rnd
);

  logic [15:0] lfsr_q;
  logic [15:0] lfsr_d;

  // taps 16,15,13,4
  always_comb begin
    lfsr_d = {lfsr_q[14:0],
              lfsr_q[15] ^ lfsr_q[14] ^ lfsr_q[12] ^ lfsr_q[3]};
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lfsr_q <= 16'hace1;
    end else begin
      lfsr_q <= lfsr_d;
    end
  end

  assign rnd = lfsr_q;

endmodule

// ==== cbj_mac_model.sv ====
/*
  behavioural mac engine and shared medium facing the backoff block.
  assumes one clock; its tasks are called by the testbench.
*/
`timescale 1ns/10ps
module cbj_mac_model (
  // clock
  input wire logic clk,
  // toward the block
  output logic tx_active,
  output logic rx_active,
  output logic carrier_busy,
  output logic tx_ok,
  output logic rx_frame_seen,
  output logic coll_pulse,
  output logic [3:0] coll_attempt,
  // from the block
  input wire logic backoff_done,
  input wire logic tx_desc_close,
  input wire logic rx_desc_close
);
  initial begin
    tx_active = 1'b0;
    rx_active = 1'b0;
    carrier_busy = 1'b0;
    tx_ok = 1'b0;
    rx_frame_seen = 1'b0;
    coll_pulse = 1'b0;
    coll_attempt = 4'h1;
  end

  // one-cycle wire event: good transmit, or any frame sensed
  task automatic event_pulse(input bit sensed);
    @(posedge clk);
    if (sensed) rx_frame_seen <= 1'b1;
    else tx_ok <= 1'b1;
    @(posedge clk);
    rx_frame_seen <= 1'b0;
    tx_ok <= 1'b0;
  endtask

  // collision n; channel busy for bl cycles from the third edge on
  task automatic collide(input logic [3:0] n, input int bl,
                         output int cnt);
    @(posedge clk);
    coll_pulse <= 1'b1;
    coll_attempt <= n;
    cnt = 0;
    do begin
      @(posedge clk);
      coll_pulse <= 1'b0;
      cnt++;
      carrier_busy <= (cnt >= 3 && cnt < 3 + bl);
      #1;
    end while (!backoff_done && cnt < 20000);
    // channel back to idle between collisions
    carrier_busy <= 1'b0;
  endtask

  // frame held active until a descriptor closes or maxc edges pass
  task automatic frame(input bit is_tx, input int maxc, output int cnt);
    @(posedge clk);
    if (is_tx) tx_active <= 1'b1;
    else rx_active <= 1'b1;
    cnt = 0;
    do begin
      @(posedge clk);
      cnt++;
      #1;
    end while (!(tx_desc_close || rx_desc_close) && cnt < maxc);
  endtask

  task automatic frame_end();
    @(posedge clk);
    tx_active <= 1'b0;
    rx_active <= 1'b0;
  endtask
endmodule

// ==== tb_cbj_top.sv ====
/*
  self-checking bench for the capture backoff / jabber block.
  assumes the design files and the mac model are compiled first.
*/
`timescale 1ns/10ps
`include "cbj_defines.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  num_errors++; $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb_cbj_top;
  localparam int unsigned SLOT = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic tx_active, rx_active, carrier_busy, tx_ok, rx_frame_seen;
  logic coll_pulse, backoff_busy, backoff_done;
  logic [3:0] coll_attempt;
  logic tx_cutoff, rx_cutoff, col_to_mac;
  logic tx_desc_close, tx_jab, tx_late, rx_desc_close, rx_wdg;
  int num_errors = 0;
  int samples_checked = 0;

  always #2 clk = ~clk;

  cbj_top #(.SLOT_CYCLES(SLOT)) cbj_top_inst (
    .clk(clk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .tx_active(tx_active),
    .rx_active(rx_active), .carrier_busy(carrier_busy), .tx_ok(tx_ok),
    .rx_frame_seen(rx_frame_seen), .coll_pulse(coll_pulse),
    .coll_attempt(coll_attempt), .backoff_busy(backoff_busy),
    .backoff_done(backoff_done), .tx_cutoff(tx_cutoff),
    .rx_cutoff(rx_cutoff), .col_to_mac(col_to_mac),
    .tx_desc_close(tx_desc_close), .tx_jabber_timeout_flag(tx_jab),
    .tx_late_collision_flag(tx_late), .rx_desc_close(rx_desc_close),
    .rx_watchdog_expired_flag(rx_wdg), .irq(irq));

  cbj_mac_model cbj_mac_model_inst (
    .clk(clk), .tx_active(tx_active), .rx_active(rx_active),
    .carrier_busy(carrier_busy), .tx_ok(tx_ok),
    .rx_frame_seen(rx_frame_seen), .coll_pulse(coll_pulse),
    .coll_attempt(coll_attempt), .backoff_done(backoff_done),
    .tx_desc_close(tx_desc_close), .rx_desc_close(rx_desc_close));

  // ----------------------------------------------------------------
  // bus master and checks
  // ----------------------------------------------------------------
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] resp);
    int t;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (t = 0; t < 100; t++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    resp = bresp;
    bready <= 1'b0;
    if (t == 100) begin
      num_errors++;
      stop_test();
    end
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] resp);
    int t;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (t = 0; t < 100; t++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
    if (t == 100) begin
      num_errors++;
      stop_test();
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    `CHK("rd_data", e, d)
    `CHK("rd_resp", er, r)
  endtask

  // standard draw: whole slots, fewer than 2^min(n,10)
  task automatic bo_rand(input logic [3:0] n, input int bl);
    int c;
    int k;
    cbj_mac_model_inst.collide(n, bl, c);
    k = (n < 10) ? n : 10;
    `CHK("bo_align", 1'b1, (c - 3) % SLOT == 0)
    `CHK("bo_range", 1'b1, (c - 3) / SLOT < (1 << k))
  endtask

  task automatic bo_fixed(input logic [3:0] n, input int bl, input int e);
    int c;
    cbj_mac_model_inst.collide(n, bl, c);
    `CHK("bo_cycles", e, c)
    `CHK("bo_end", 2'h2, {backoff_done, backoff_busy})
  endtask

  task automatic stop_test();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial begin
    #400000;
    num_errors++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    int c;
    int lim;
    void'($urandom(22));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd_chk(`CBJ_ADDR_CTRL, 32'h0, `CBJ_RESP_OK);
    rd_chk(`CBJ_ADDR_JAB_LIM, 32'h07a120, `CBJ_RESP_OK);
    rd_chk(`CBJ_ADDR_WDG_LIM, 32'h07a120, `CBJ_RESP_OK);
    rd_chk(`CBJ_ADDR_INT_EN, 32'h0, `CBJ_RESP_OK);
    rd_chk(8'h1c, 32'h0, `CBJ_RESP_ERR);
    axi_wr(`CBJ_ADDR_STATUS, 32'hf, r);
    `CHK("ro_wr_resp", `CBJ_RESP_ERR, r)
    // mitigation off: a good frame changes nothing
    cbj_mac_model_inst.event_pulse(1'b0);
    for (int n = 1; n < 16; n++) bo_rand(4'(n), 0);
    axi_wr(`CBJ_ADDR_CTRL, 32'h1, r);
    cbj_mac_model_inst.event_pulse(1'b0);
    axi_rd(`CBJ_ADDR_STATUS, d, r);
    `CHK("mode_on", 1'b1, d[0])
    bo_fixed(4'h1, 0, 2 * SLOT + 3);
    bo_fixed(4'h2, 0, 3);
    bo_rand(4'h3, 5);
    bo_fixed(4'h1, 5, 2 * SLOT + 3);
    axi_wr(`CBJ_ADDR_CTRL, 32'h3, r);
    bo_fixed(4'h1, 5, 2 * SLOT + 3 + 5);
    bo_fixed(4'h2, 5, 3);
    bo_rand(4'h3, 5);
    cbj_mac_model_inst.event_pulse(1'b1);
    bo_rand(4'h1, 0);
    axi_rd(`CBJ_ADDR_STATUS, d, r);
    `CHK("mode_off", 1'b0, d[0])
    cbj_mac_model_inst.event_pulse(1'b0);
    axi_wr(`CBJ_ADDR_CTRL, 32'h0, r);
    bo_rand(4'h1, 0);
    // jabber on a transmit frame
    axi_wr(`CBJ_ADDR_INT_CLR, 32'h7, r);
    axi_wr(`CBJ_ADDR_INT_EN, 32'h1, r);
    lim = 8 + $urandom % 32;
    axi_wr(`CBJ_ADDR_JAB_LIM, 32'(lim), r);
    cbj_mac_model_inst.frame(1'b1, 200, c);
    `CHK("jab_at", lim + 1, c)
    `CHK("jab_out", 4'hf, {tx_jab, tx_late, tx_desc_close, col_to_mac})
    `CHK("jab_cut", 2'h3, {tx_cutoff, rx_cutoff})
    cbj_mac_model_inst.frame_end();
    axi_rd(`CBJ_ADDR_INT_STAT, d, r);
    `CHK("jab_stat", 1'b1, d[0])
    `CHK("irq_on", 1'b1, irq)
    axi_wr(`CBJ_ADDR_INT_CLR, 32'h1, r);
    repeat (2) @(posedge clk);
    #1;
    `CHK("jab_clr", 3'h0, {irq, tx_cutoff, rx_cutoff})
    // receive watchdog, its interrupt masked at first
    axi_wr(`CBJ_ADDR_WDG_LIM, 32'(lim + 3), r);
    cbj_mac_model_inst.frame(1'b0, 200, c);
    `CHK("wdg_at", lim + 4, c)
    `CHK("wdg_out", 4'hf, {rx_wdg, rx_desc_close, tx_cutoff, rx_cutoff})
    cbj_mac_model_inst.frame_end();
    repeat (2) @(posedge clk);
    #1;
    `CHK("irq_mask", 1'b0, irq)
    axi_wr(`CBJ_ADDR_INT_EN, 32'h2, r);
    repeat (2) @(posedge clk);
    #1;
    `CHK("irq_wdg", 1'b1, irq)
    axi_wr(`CBJ_ADDR_INT_CLR, 32'h2, r);
    repeat (2) @(posedge clk);
    #1;
    `CHK("wdg_clr", 2'h0, {irq, rx_cutoff})
    stop_test();
  end
endmodule
